// ---- logic/gwr_regmap.sv ----
`timescale 1ns/1ns
`default_nettype none
module gwr_regmap #(
  parameter int IN_WORDS = 1024,
  parameter int OUT_WORDS = 1024,
  parameter int ACY_WORDS = 256,
  parameter int CYC_PER_MS = gwr_pkg::CYC_PER_MS,
  parameter logic [191:0] NAME_STR = "GATEWAY-MB-TCP-X00000000" // Arbitrary value
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Modbus register access, one word per request
  input wire gwr_pkg::gwr_req_s req_i,
  input wire logic frame_i,
  output gwr_pkg::gwr_rsp_s rsp_o,
  // Field side input data
  input wire logic in_start_i,
  input wire logic in_flush_i,
  input wire gwr_pkg::gwr_item_s in_item_i,
  output logic in_ready_o,
  // Field side output data
  input wire logic [15:0] out_bits_i,
  input wire logic [$clog2(OUT_WORDS)-1:0] out_rd_addr_i,
  output logic [15:0] out_rd_data_o,
  output logic outputs_off_o,
  // Gateway condition and connection state
  input wire logic [15:0] condition_i,
  output logic [15:0] conn_mode_o,
  output logic conn_lost_o,
  output logic restore_pulse_o,
  output logic save_pulse_o,
  output logic [15:0] wd_limit_o,
  // Acyclic agent port
  input wire logic acy_wr_i,
  input wire logic [$clog2(ACY_WORDS)-1:0] acy_addr_i,
  input wire logic [15:0] acy_wdata_i,
  output logic [15:0] acy_rdata_o
);
  import gwr_pkg::*;
  localparam int IAW = $clog2(IN_WORDS);
  localparam int OAW = $clog2(OUT_WORDS);
  localparam int CAW = $clog2(ACY_WORDS);

  if (IN_WORDS > 1024 || OUT_WORDS > 1024 || ACY_WORDS != 256 || CYC_PER_MS < 1) begin : g_chk
    $error("gwr_regmap: unsupported size parameter");
  end

  // ****************************************
  // Address decode
  // ****************************************
  function automatic gwr_region_e decode(input logic [15:0] a);
    gwr_region_e r;
    r = RG_NONE;
    if (a <= IN_LAST) r = RG_IN;
    else if (a >= OUT_BASE && a <= OUT_LAST) r = RG_OUT;
    else if (a >= NAME_BASE && a <= NAME_LAST) r = RG_NAME;
    else if (a >= ACY_BASE && a <= ACY_LAST) r = RG_ACY;
    else begin
      case (a)
        COND_ADDR: r = RG_COND;
        OUT_BITS_ADDR: r = RG_OUT_BITS;
        IN_BITS_ADDR: r = RG_IN_BITS;
        VERSION_ADDR: r = RG_VERSION;
        WD_RUN_ADDR: r = RG_WD_RUN;
        WD_LIMIT_ADDR: r = RG_WD_LIMIT;
        WD_RETRIG_ADDR: r = RG_WD_RETRIG;
        MODE_ADDR: r = RG_MODE;
        SUP_ADDR: r = RG_SUP;
        RESTORE_A_ADDR: r = RG_RESTORE_A;
        RESTORE_B_ADDR: r = RG_RESTORE_B;
        SAVE_A_ADDR: r = RG_SAVE_A;
        SAVE_B_ADDR: r = RG_SAVE_B;
        default: r = RG_NONE;
      endcase
    end
    return r;
  endfunction

  function automatic logic writable(input gwr_region_e r);
    case (r)
      RG_OUT, RG_WD_LIMIT, RG_WD_RETRIG, RG_MODE, RG_SUP, RG_RESTORE_A, RG_RESTORE_B,
      RG_SAVE_A, RG_SAVE_B, RG_ACY: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  gwr_region_e reg_sel;
  logic wr_ok;
  assign reg_sel = decode(req_i.addr);
  assign wr_ok = req_i.valid && req_i.write && writable(reg_sel);

  // ****************************************
  // Storage
  // ****************************************
  logic [15:0] in_mem [IN_WORDS];
  logic [15:0] out_mem [OUT_WORDS];
  logic [15:0] acy_mem [ACY_WORDS];
  logic pk_wr;
  logic [IAW-1:0] pk_addr;
  logic [15:0] pk_data;
  logic [15:0] in_bits;
  logic [15:0] wd_ms_q, wd_limit_q, retrig_q, mode_q, sup_q;
  logic [15:0] rest_a_q, rest_b_q, save_a_q, save_b_q;

  gwr_packer #(.WORDS(IN_WORDS)) u_packer (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .start_i(in_start_i),
    .flush_i(in_flush_i),
    .item_i(in_item_i),
    .ready_o(in_ready_o),
    .wr_en_o(pk_wr),
    .wr_addr_o(pk_addr),
    .wr_data_o(pk_data),
    .bits_o(in_bits)
  );

  always_ff @(posedge mclk_i) begin
    if (pk_wr) begin
      in_mem[pk_addr] <= pk_data;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (wr_ok && reg_sel == RG_OUT) begin
      out_mem[req_i.addr[OAW-1:0]] <= req_i.wdata;
    end
  end

  // Client writes win over the agent in the same cycle; the agent owns results by protocol.
  always_ff @(posedge mclk_i) begin
    if (wr_ok && reg_sel == RG_ACY) begin
      acy_mem[req_i.addr[CAW-1:0]] <= req_i.wdata;
    end else if (acy_wr_i) begin
      acy_mem[acy_addr_i] <= acy_wdata_i;
    end
    acy_rdata_o <= acy_mem[acy_addr_i];
  end

  // Outputs are forced to zero after a monitoring timeout
  always_ff @(posedge mclk_i) begin
    if (srst_i || outputs_off_o) begin
      out_rd_data_o <= 16'h0000;
    end else begin
      out_rd_data_o <= out_mem[out_rd_addr_i];
    end
  end

  // ****************************************
  // Read answer
  // ****************************************
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rsp_o <= '0;
    end else begin
      rsp_o.valid <= req_i.valid;
      rsp_o.exc <= req_i.valid && (reg_sel == RG_NONE || (req_i.write && !writable(reg_sel)));
      rsp_o.rdata <= 16'h0000;
      if (req_i.valid && !req_i.write) begin
        case (reg_sel)
          RG_IN: rsp_o.rdata <= in_mem[req_i.addr[IAW-1:0]];
          RG_OUT: rsp_o.rdata <= out_mem[req_i.addr[OAW-1:0]];
          RG_NAME: rsp_o.rdata <= NAME_STR[16*(NAME_LAST - req_i.addr) +: 16];
          RG_COND: rsp_o.rdata <= condition_i;
          RG_OUT_BITS: rsp_o.rdata <= out_bits_i;
          RG_IN_BITS: rsp_o.rdata <= in_bits;
          RG_VERSION: rsp_o.rdata <= VERSION_VAL;
          RG_WD_RUN: rsp_o.rdata <= wd_ms_q;
          RG_WD_LIMIT: rsp_o.rdata <= wd_limit_q;
          RG_WD_RETRIG: rsp_o.rdata <= retrig_q;
          RG_MODE: rsp_o.rdata <= mode_q;
          RG_SUP: rsp_o.rdata <= sup_q;
          RG_RESTORE_A: rsp_o.rdata <= rest_a_q;
          RG_RESTORE_B: rsp_o.rdata <= rest_b_q;
          RG_SAVE_A: rsp_o.rdata <= save_a_q;
          RG_SAVE_B: rsp_o.rdata <= save_b_q;
          RG_ACY: rsp_o.rdata <= acy_mem[req_i.addr[CAW-1:0]];
          default: rsp_o.rdata <= 16'h0000;
        endcase
      end
    end
  end

  // ****************************************
  // Millisecond tick
  // ****************************************
  logic [$clog2(CYC_PER_MS+1)-1:0] pre_q;
  logic ms_tick;
  assign ms_tick = (pre_q == ($clog2(CYC_PER_MS+1))'(CYC_PER_MS - 1));
  always_ff @(posedge mclk_i) begin
    if (srst_i || ms_tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + 1'b1;
    end
  end

  // ****************************************
  // Time monitoring
  // ****************************************
  logic restart;
  assign restart = frame_i || (wr_ok && reg_sel == RG_WD_RETRIG);
  always_ff @(posedge mclk_i) begin
    if (srst_i || restart) begin
      wd_ms_q <= 16'h0000;
    end else if (ms_tick && wd_ms_q != 16'hFFFF) begin
      wd_ms_q <= wd_ms_q + 16'h0001;
    end
  end

  // A limit of zero leaves outputs on forever; that is the documented hazard.
  always_ff @(posedge mclk_i) begin
    if (srst_i || restart) begin
      outputs_off_o <= 1'b0;
    end else if (wd_limit_q != 16'h0000 && wd_ms_q >= wd_limit_q) begin
      outputs_off_o <= 1'b1;
    end
  end

  // Connection supervision counts whole seconds between frames
  logic [9:0] sup_ms_q;
  logic [15:0] sup_s_q;
  always_ff @(posedge mclk_i) begin
    if (srst_i || frame_i) begin
      sup_ms_q <= 10'h000;
      sup_s_q <= 16'h0000;
      conn_lost_o <= 1'b0;
    end else begin
      if (ms_tick) begin
        sup_ms_q <= (sup_ms_q == 10'(MS_PER_S - 1)) ? 10'h000 : sup_ms_q + 10'h001;
      end
      if (ms_tick && sup_ms_q == 10'(MS_PER_S - 1) && sup_s_q != 16'hFFFF) begin
        sup_s_q <= sup_s_q + 16'h0001;
      end
      conn_lost_o <= sup_q != SUP_RST && sup_s_q >= sup_q;
    end
  end

  // ****************************************
  // Configuration registers and keys
  // ****************************************
  logic rest_arm_q, save_arm_q;
  logic [15:0] rest_ms_q, save_ms_q;
  logic rest_go, save_go;
  assign rest_go = wr_ok && reg_sel == RG_RESTORE_B && req_i.wdata == RESTORE_KEY_B && rest_arm_q;
  assign save_go = wr_ok && reg_sel == RG_SAVE_B && req_i.wdata == SAVE_KEY_B && save_arm_q;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      wd_limit_q <= WD_LIMIT_RST;
      retrig_q <= 16'h0000;
      mode_q <= 16'h0000;
      sup_q <= SUP_RST;
    end else begin
      if (rest_go) begin
        wd_limit_q <= WD_LIMIT_RST;
      end else if (wr_ok && reg_sel == RG_WD_LIMIT) begin
        wd_limit_q <= req_i.wdata;
      end
      if (wr_ok && reg_sel == RG_WD_RETRIG) retrig_q <= req_i.wdata;
      if (wr_ok && reg_sel == RG_MODE) mode_q <= req_i.wdata;
      if (wr_ok && reg_sel == RG_SUP) sup_q <= req_i.wdata;
    end
  end

  // First key arms a 30 s window; any other first value disarms it.
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      rest_a_q <= 16'h0000;
      rest_b_q <= 16'h0000;
      rest_arm_q <= 1'b0;
      rest_ms_q <= 16'h0000;
      restore_pulse_o <= 1'b0;
    end else begin
      restore_pulse_o <= rest_go;
      if (wr_ok && reg_sel == RG_RESTORE_A) begin
        rest_a_q <= req_i.wdata;
        rest_arm_q <= req_i.wdata == RESTORE_KEY_A;
        rest_ms_q <= 16'h0000;
      end else if (rest_go || (ms_tick && rest_ms_q == 16'(KEY_WINDOW_MS - 1))) begin
        rest_arm_q <= 1'b0;
      end else if (ms_tick && rest_arm_q) begin
        rest_ms_q <= rest_ms_q + 16'h0001;
      end
      if (wr_ok && reg_sel == RG_RESTORE_B) rest_b_q <= req_i.wdata;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      save_a_q <= 16'h0000;
      save_b_q <= 16'h0000;
      save_arm_q <= 1'b0;
      save_ms_q <= 16'h0000;
      save_pulse_o <= 1'b0;
    end else begin
      save_pulse_o <= save_go;
      if (wr_ok && reg_sel == RG_SAVE_A) begin
        save_a_q <= req_i.wdata;
        save_arm_q <= req_i.wdata == SAVE_KEY_A;
        save_ms_q <= 16'h0000;
      end else if (save_go || (ms_tick && save_ms_q == 16'(KEY_WINDOW_MS - 1))) begin
        save_arm_q <= 1'b0;
      end else if (ms_tick && save_arm_q) begin
        save_ms_q <= save_ms_q + 16'h0001;
      end
      if (wr_ok && reg_sel == RG_SAVE_B) save_b_q <= req_i.wdata;
    end
  end

  assign conn_mode_o = mode_q;
  assign wd_limit_o = wd_limit_q;

  // ****************************************
  // Assertions
  // ****************************************
  rsp_timing_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    req_i.valid |=> rsp_o.valid ##1 (rsp_o.valid == $past(req_i.valid)))
    else $error("answer not one cycle after request");
  unmapped_exc_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && decode(req_i.addr) == RG_NONE) |=> rsp_o.exc)
    else $error("unmapped address without exception");
  in_readonly_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && req_i.write && req_i.addr <= IN_LAST) |=> rsp_o.exc)
    else $error("write to input image accepted");
  version_read_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && !req_i.write && req_i.addr == VERSION_ADDR) |=> (rsp_o.rdata == VERSION_VAL && !rsp_o.exc))
    else $error("version word wrong");
  limit_write_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && req_i.write && req_i.addr == WD_LIMIT_ADDR) |=> wd_limit_q == $past(req_i.wdata))
    else $error("limit write lost");
  wd_restart_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    frame_i |=> (wd_ms_q == 16'h0000 && !outputs_off_o))
    else $error("frame did not restart monitoring");
  outputs_off_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    outputs_off_o |=> out_rd_data_o == 16'h0000)
    else $error("outputs not forced off");
  restore_key_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    rest_go |=> (wd_limit_q == WD_LIMIT_RST && restore_pulse_o) ##1 !restore_pulse_o)
    else $error("restore sequence failed");
  save_key_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (req_i.valid && req_i.write && req_i.addr == SAVE_B_ADDR && !save_arm_q) |=> !save_pulse_o)
    else $error("save without arming");
  restore_cov: cover property (@(posedge mclk_i) rest_go);
  save_cov: cover property (@(posedge mclk_i) save_go);
  expire_cov: cover property (@(posedge mclk_i) $rose(outputs_off_o));
endmodule // gwr_regmap
`default_nettype wire

// ---- logic/gwr_pkg.sv ----
package gwr_pkg;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [15:0] IN_BASE = 16'h0000;
  localparam logic [15:0] IN_LAST = 16'h03FF;
  localparam logic [15:0] OUT_BASE = 16'h0800;
  localparam logic [15:0] OUT_LAST = 16'h0BFF;
  localparam logic [15:0] NAME_BASE = 16'h1000;
  localparam logic [15:0] NAME_LAST = 16'h100B;
  localparam logic [15:0] COND_ADDR = 16'h100C;
  localparam logic [15:0] OUT_BITS_ADDR = 16'h1012;
  localparam logic [15:0] IN_BITS_ADDR = 16'h1013;
  localparam logic [15:0] VERSION_ADDR = 16'h1017;
  localparam logic [15:0] WD_RUN_ADDR = 16'h1020;
  localparam logic [15:0] WD_LIMIT_ADDR = 16'h1120;
  localparam logic [15:0] WD_RETRIG_ADDR = 16'h1121;
  localparam logic [15:0] MODE_ADDR = 16'h1130;
  localparam logic [15:0] SUP_ADDR = 16'h1131;
  localparam logic [15:0] RESTORE_A_ADDR = 16'h113C;
  localparam logic [15:0] RESTORE_B_ADDR = 16'h113D;
  localparam logic [15:0] SAVE_A_ADDR = 16'h113E;
  localparam logic [15:0] SAVE_B_ADDR = 16'h113F;
  localparam logic [15:0] ACY_BASE = 16'h8000;
  localparam logic [15:0] ACY_LAST = 16'h80FF;
  // ****************************************
  // Values and keys
  // ****************************************
  localparam logic [15:0] VERSION_VAL = 16'h0001;
  localparam logic [15:0] WD_LIMIT_RST = 16'h0BB8;
  localparam logic [15:0] SUP_RST = 16'h0000;
  localparam logic [15:0] RESTORE_KEY_A = 16'h6C6F;
  localparam logic [15:0] RESTORE_KEY_B = 16'h6164;
  localparam logic [15:0] SAVE_KEY_A = 16'h7361;
  localparam logic [15:0] SAVE_KEY_B = 16'h7665;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam int MS_PER_S = 1000;
  localparam int KEY_WINDOW_S = 30;
  localparam int KEY_WINDOW_MS = KEY_WINDOW_S * MS_PER_S;
  // ****************************************
  // Types
  // ****************************************
  typedef enum {RG_NONE, RG_IN, RG_OUT, RG_NAME, RG_COND, RG_OUT_BITS, RG_IN_BITS, RG_VERSION,
                RG_WD_RUN, RG_WD_LIMIT, RG_WD_RETRIG, RG_MODE, RG_SUP, RG_RESTORE_A,
                RG_RESTORE_B, RG_SAVE_A, RG_SAVE_B, RG_ACY} gwr_region_e;
  typedef struct packed {
    logic valid;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } gwr_req_s;
  typedef struct packed {
    logic valid;
    logic exc;
    logic [15:0] rdata;
  } gwr_rsp_s;
  typedef struct packed {
    logic valid;
    logic is_word;
    logic [15:0] data;
  } gwr_item_s;
endpackage : gwr_pkg

// ---- logic/gwr_packer.sv ----
`timescale 1ns/1ns
`default_nettype none
module gwr_packer #(
  parameter int WORDS = 1024
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic srst_i,
  // Item stream
  input wire logic start_i,
  input wire logic flush_i,
  input wire gwr_pkg::gwr_item_s item_i,
  output logic ready_o,
  // Image write port
  output logic wr_en_o,
  output logic [$clog2(WORDS)-1:0] wr_addr_o,
  output logic [15:0] wr_data_o,
  output logic [15:0] bits_o
);
  import gwr_pkg::*;
  localparam int AW = $clog2(WORDS);

  // The bit length word holds at most 8191 bytes
  if (WORDS < 2 || WORDS > 2048) begin : g_chk
    $error("gwr_packer: unsupported WORDS");
  end

  logic half_q;
  logic [7:0] held_q;
  logic pend_q;
  logic [15:0] pend_data_q;
  logic [AW-1:0] ptr_q;
  logic [15:0] bytes_q;
  logic take;
  assign take = item_i.valid && ready_o;

  // ****************************************
  // Packing
  // ****************************************
  // A word arriving behind an odd byte needs two writes; stalling one cycle
  // keeps a single write port instead of a dual-ported image.
  always_ff @(posedge mclk_i) begin
    wr_en_o <= 1'b0;
    if (srst_i || start_i) begin
      half_q <= 1'b0;
      held_q <= 8'h00;
      pend_q <= 1'b0;
      pend_data_q <= 16'h0000;
      ptr_q <= '0;
      bytes_q <= 16'h0000;
      ready_o <= 1'b1;
      wr_addr_o <= '0;
      wr_data_o <= 16'h0000;
    end else if (pend_q) begin
      wr_en_o <= 1'b1;
      wr_addr_o <= ptr_q;
      wr_data_o <= pend_data_q;
      ptr_q <= ptr_q + 1'b1;
      bytes_q <= bytes_q + 16'h0002;
      pend_q <= 1'b0;
      ready_o <= 1'b1;
    end else if (take && !item_i.is_word && !half_q) begin
      held_q <= item_i.data[7:0];
      half_q <= 1'b1;
    end else if (take && !item_i.is_word) begin
      wr_en_o <= 1'b1;
      wr_addr_o <= ptr_q;
      wr_data_o <= {held_q, item_i.data[7:0]};
      ptr_q <= ptr_q + 1'b1;
      bytes_q <= bytes_q + 16'h0002;
      half_q <= 1'b0;
    end else if (take && half_q) begin
      wr_en_o <= 1'b1;
      wr_addr_o <= ptr_q;
      wr_data_o <= {held_q, PAD_BYTE};
      ptr_q <= ptr_q + 1'b1;
      bytes_q <= bytes_q + 16'h0002;
      half_q <= 1'b0;
      pend_q <= 1'b1;
      pend_data_q <= item_i.data;
      ready_o <= 1'b0;
    end else if (take) begin
      wr_en_o <= 1'b1;
      wr_addr_o <= ptr_q;
      wr_data_o <= item_i.data;
      ptr_q <= ptr_q + 1'b1;
      bytes_q <= bytes_q + 16'h0002;
    end else if (flush_i && half_q) begin
      wr_en_o <= 1'b1;
      wr_addr_o <= ptr_q;
      wr_data_o <= {held_q, PAD_BYTE};
      ptr_q <= ptr_q + 1'b1;
      bytes_q <= bytes_q + 16'h0002;
      half_q <= 1'b0;
    end
  end

  assign bits_o = {bytes_q[12:0], 3'b000};

  pad_stall_a: assert property (@(posedge mclk_i) disable iff (srst_i)
    (take && item_i.is_word && half_q && !start_i) |=> (!ready_o && wr_data_o[7:0] == PAD_BYTE) ##1 ready_o)
    else $error("padding write or stall missing");
  pad_cov: cover property (@(posedge mclk_i) take && item_i.is_word && half_q);
endmodule // gwr_packer
`default_nettype wire

// ---- dv/gwr_client.sv ----
`timescale 1ns/1ns
`default_nettype none
// Modbus client model, one word per request
module gwr_client (
  // Clock
  input wire logic mclk_i,
  // Register access
  output var gwr_pkg::gwr_req_s req_o,
  input wire gwr_pkg::gwr_rsp_s rsp_i
);
  import gwr_pkg::*;
  initial req_o = '0;
  task automatic xfer(input logic w, input logic [15:0] a, d, output logic e, output logic [15:0] q);
    int n;
    n = 0;
    @(negedge mclk_i);
    req_o = {1'b1, w, a, d};
    @(negedge mclk_i);
    // Released lines show the inverse so stale values never pass
    req_o = {1'b0, ~w, ~a, ~d};
    while (rsp_i.valid !== 1'b1 && n < 2) begin
      @(negedge mclk_i);
      n++;
    end
    e = (rsp_i.valid === 1'b1) ? rsp_i.exc : 1'bx;
    q = rsp_i.rdata;
  endtask
  // Key pair: first word, then second within the window
  task automatic keys(input logic [15:0] a, k1, k2);
    logic e;
    logic [15:0] q;
    xfer(1'b1, a, k1, e, q);
    xfer(1'b1, a + 16'h0001, k2, e, q);
  endtask
endmodule // gwr_client
`default_nettype wire

// ---- dv/gwr_regmap_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module gwr_regmap_tb;
  import gwr_pkg::*;
  logic mclk = 0, srst = 1, frame = 0, st = 0, fl = 0, rdy, off, lost, rp, sp;
  logic [15:0] obits = 0, cond = 0, mode, lim, odat, acyq;
  gwr_item_s item = '0;
  gwr_req_s req;
  gwr_rsp_s rsp;
  int num_errors = 0, cmp_count = 0, cyc = 0, rp_n = 0, sp_n = 0;
  always #10 mclk = ~mclk;
  // CYC_PER_MS shortened so a 5 ms monitoring limit expires in about 50 cycles
  gwr_regmap #(.CYC_PER_MS(10)) dut (.mclk_i(mclk), .srst_i(srst), .req_i(req), .frame_i(frame),
    .rsp_o(rsp), .in_start_i(st), .in_flush_i(fl), .in_item_i(item), .in_ready_o(rdy),
    .out_bits_i(obits), .out_rd_addr_i('0), .out_rd_data_o(odat), .outputs_off_o(off),
    .condition_i(cond), .conn_mode_o(mode), .conn_lost_o(lost), .restore_pulse_o(rp),
    .save_pulse_o(sp), .wd_limit_o(lim), .acy_wr_i(1'b0), .acy_addr_i('0), .acy_wdata_i('0),
    .acy_rdata_o(acyq));
  gwr_client client (.mclk_i(mclk), .req_o(req), .rsp_i(rsp));
  always @(posedge mclk) begin
    rp_n += (rp === 1'b1);
    sp_n += (sp === 1'b1);
    cyc++;
    // The supervision scenario alone waits about 10000 cycles, one second of shortened ticks
    if (cyc == 30000) begin
      num_errors++;
      conclude();
    end
  end
  task automatic conclude();
    if (num_errors == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string s, input logic [16:0] x, g);
    cmp_count++;
    if (g !== x) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", s, x, g);
    end
  endtask
  // ****************************************
  // Bus helpers: exception bit and data compared together
  // ****************************************
  task automatic rd(input logic [15:0] a, input logic e, input logic [15:0] d, input string s);
    logic ge;
    logic [15:0] gq;
    client.xfer(1'b0, a, 16'h0000, ge, gq);
    chk(s, {e, e ? 16'h0000 : d}, {ge, gq});
  endtask
  task automatic wr(input logic [15:0] a, d, input logic e, input string s);
    logic ge;
    logic [15:0] gq;
    client.xfer(1'b1, a, d, ge, gq);
    chk(s, {e, 16'h0000}, {ge, gq});
  endtask
  task automatic put(input logic w, input logic [15:0] d);
    while (rdy !== 1'b1) @(negedge mclk);
    item = {1'b1, w, d};
    @(negedge mclk);
  endtask
  task automatic t_reset();
    rd(WD_LIMIT_ADDR, 0, WD_LIMIT_RST, "limit");
    rd(SUP_ADDR, 0, SUP_RST, "sup");
    rd(VERSION_ADDR, 0, VERSION_VAL, "ver");
    wr(VERSION_ADDR, 16'h0002, 1, "ver wr");
  endtask
  task automatic t_map();
    logic ge;
    logic [15:0] gq;
    wr(OUT_BASE, 16'hFFFF, 0, "out0 wr");
    wr(OUT_LAST, 16'h0000, 0, "outN wr");
    rd(OUT_BASE, 0, 16'hFFFF, "out0");
    rd(OUT_LAST, 0, 16'h0000, "outN");
    wr(IN_BASE, 16'h1234, 1, "in wr");
    wr(NAME_BASE, 16'h1234, 1, "name wr");
    rd(NAME_BASE, 0, 16'h4741, "name");
    rd(16'h0400, 1, 16'h0000, "gap");
    wr(16'h8100, 16'h0001, 1, "gap wr");
    client.xfer(1'b0, ACY_LAST, 16'h0000, ge, gq);
    chk("acy", 17'h0, {ge, 16'h0000});
    wr(ACY_BASE, 16'h5AA5, 0, "acy wr");
    rd(ACY_BASE, 0, 16'h5AA5, "acy rd");
    chk("acy agent", 17'h05AA5, {1'b0, acyq});
    cond = 16'h0081;
    rd(COND_ADDR, 0, 16'h0081, "cond");
    wr(MODE_ADDR, 16'h00A5, 0, "mode wr");
    chk("mode", 17'h000A5, {1'b0, mode});
    rd(MODE_ADDR, 0, 16'h00A5, "mode");
  endtask
  task automatic t_pack();
    obits = 16'd5136;
    rd(OUT_BITS_ADDR, 0, 16'd5136, "obits");
    st = 1;
    @(negedge mclk);
    st = 0;
    put(0, 16'h00A1);
    put(0, 16'h00B2);
    put(0, 16'h00C3);
    put(1, 16'h1357);
    chk("rdy", 17'h0, {16'h0, rdy});
    item = '0;
    rd(IN_BASE, 0, 16'hA1B2, "w0");
    rd(IN_BASE + 1, 0, {8'hC3, PAD_BYTE}, "w1");
    rd(IN_BASE + 2, 0, 16'h1357, "w2");
    rd(IN_BITS_ADDR, 0, 16'd48, "ibits");
    put(0, 16'h00D4);
    item = '0;
    fl = 1;
    @(negedge mclk);
    fl = 0;
    rd(IN_BASE + 3, 0, {8'hD4, PAD_BYTE}, "w3");
    rd(IN_BITS_ADDR, 0, 16'd64, "ibits fl");
  endtask
  task automatic t_wd();
    int n;
    n = 0;
    wr(WD_LIMIT_ADDR, 16'h0005, 0, "lim wr");
    wr(WD_RETRIG_ADDR, 16'h0001, 0, "retrig");
    repeat (40) @(negedge mclk);
    chk("off early", 17'h0, {16'h0, off});
    chk("odat on", 17'h0FFFF, {1'b0, odat});
    while (off !== 1'b1 && n < 20) begin
      @(negedge mclk);
      n++;
    end
    chk("off", 17'h1, {16'h0, off});
    @(negedge mclk);
    chk("odat off", 17'h0, {1'b0, odat});
    // Expiry trails a millisecond tick, so no tick falls before the read
    wr(WD_RETRIG_ADDR, 16'h0001, 0, "retrig 2");
    rd(WD_RUN_ADDR, 0, 16'h0000, "run");
    chk("off rt", 17'h0, {16'h0, off});
    repeat (100) @(negedge mclk);
    chk("off 2", 17'h1, {16'h0, off});
    frame = 1;
    @(negedge mclk);
    frame = 0;
    repeat (2) @(negedge mclk);
    chk("off fr", 17'h0, {16'h0, off});
  endtask
  task automatic t_keys();
    int n;
    n = 0;
    client.keys(RESTORE_A_ADDR, 16'h1111, RESTORE_KEY_B);
    repeat (2) @(negedge mclk);
    chk("no rst", 17'h0, rp_n[16:0]);
    client.keys(RESTORE_A_ADDR, RESTORE_KEY_A, RESTORE_KEY_B);
    repeat (2) @(negedge mclk);
    chk("rst", 17'h1, rp_n[16:0]);
    chk("lim", {1'b0, WD_LIMIT_RST}, {1'b0, lim});
    client.keys(SAVE_A_ADDR, SAVE_KEY_A, SAVE_KEY_B);
    repeat (2) @(negedge mclk);
    chk("save", 17'h1, sp_n[16:0]);
    chk("lost", 17'h0, {16'h0, lost});
    wr(SUP_ADDR, 16'h0001, 0, "sup wr");
    while (lost !== 1'b1 && n < 11000) begin
      @(negedge mclk);
      n++;
    end
    chk("lost 1s", 17'h1, {16'h0, lost});
    wr(SUP_ADDR, SUP_RST, 0, "sup off");
    repeat (2) @(negedge mclk);
    chk("lost off", 17'h0, {16'h0, lost});
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    srst = 0;
    t_reset();
    t_map();
    t_pack();
    t_wd();
    t_keys();
    conclude();
  end
endmodule // gwr_regmap_tb
`default_nettype wire
